// file: src/dtei_cfg.svh
`ifndef DTEI_CFG_SVH
`define DTEI_CFG_SVH

// counter and prescaler widths
`define DTEI_COUNT_W     32
`define DTEI_PRESCALE_W  8

// reset values of the per-timer configuration
`define DTEI_RELOAD_RST    32'h0000_0000
`define DTEI_PRESCALE_RST  8'h00
`define DTEI_ENABLE_RST    1'b0

// number of timer instances
`define DTEI_TIMERS      2

// bit positions inside the synchroniser vector
`define DTEI_BIT_EXT     0
`define DTEI_BIT_PRIV    1
`define DTEI_SYNC_BITS   2

`endif

// file: src/dtei_pkg.sv
`include "dtei_cfg.svh"

package dtei_pkg;

  typedef enum logic [1:0] {
    MODE_INTERNAL,
    MODE_EXT_GATE,
    MODE_EXT_CLOCK
  } dtei_mode_e;

  typedef struct packed {
    logic                          enable;
    dtei_mode_e                    mode;
    logic [`DTEI_PRESCALE_W-1:0]   prescale;
    logic [`DTEI_COUNT_W-1:0]      reload;
  } dtei_cfg_s;

  typedef struct packed {
    logic      valid;
    logic      priv;
    logic      clearInt;
    dtei_cfg_s cfg;
  } dtei_wr_s;

endpackage

// file: src/dtei_counter.sv
`timescale 1ns/1ps
`include "dtei_cfg.svh"

module dtei_counter
  import dtei_pkg::*;
#(
  parameter int COUNT_W = `DTEI_COUNT_W
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               nrst,
  // control
  input  wire logic               load,
  input  wire logic [COUNT_W-1:0] loadValue,
  input  wire logic               tick,
  input  wire logic               clearInt,
  // status
  output logic      [COUNT_W-1:0] count,
  output logic                    interrupt
);

  logic [COUNT_W-1:0] reloadQ;
  logic [COUNT_W-1:0] countD;

  if (COUNT_W < 2) begin : gWidthCheck
    $error("dtei_counter: COUNT_W must be at least 2");
  end

  // a tick at zero restarts from the reload value, otherwise count down
  always_comb begin
    if (count == '0) begin
      countD = reloadQ;
    end else begin
      countD = count - COUNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reloadQ <= COUNT_W'(`DTEI_RELOAD_RST);
    end else if (load) begin
      reloadQ <= loadValue;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= COUNT_W'(`DTEI_RELOAD_RST);
    end else if (load) begin
      count <= loadValue;
    end else if (tick) begin
      count <= countD;
    end
  end

  // set wins over clear so a terminal tick in a clearing cycle without a load is kept
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      interrupt <= 1'b0;
    end else if (tick && !load && countD == '0) begin
      interrupt <= 1'b1;
    end else if (clearInt) begin
      interrupt <= 1'b0;
    end
  end

endmodule // dtei_counter

// file: src/dtei_top.sv
// Function
// - each external input passes a two-stage synchroniser on the timer clock before use.
// - external clock mode drives the timer from detected edges, not the raw level.
// - with privileged-only tie-off set, unprivileged configuration writes are ignored once the tie-off has passed the synchroniser and filter.
// - two independent timers, each with its own one-bit interrupt output.
`timescale 1ns/1ps
`include "dtei_cfg.svh"

module dtei_top
  import dtei_pkg::*;
#(
  parameter int COUNT_W    = `DTEI_COUNT_W,
  parameter int PRESCALE_W = `DTEI_PRESCALE_W
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               nrst,
  // timer a pins
  input  wire logic               timerAExternalInput,
  input  wire logic               timerAPrivilegedWriteOnly,
  output logic                    timerAInterrupt,
  // timer b pins
  input  wire logic               timerBExternalInput,
  input  wire logic               timerBPrivilegedWriteOnly,
  output logic                    timerBInterrupt,
  // timer a configuration write port
  input  wire dtei_wr_s           timerAWrite,
  output logic                    timerAWriteAccepted,
  output logic      [COUNT_W-1:0] timerACount,
  // timer b configuration write port
  input  wire dtei_wr_s           timerBWrite,
  output logic                    timerBWriteAccepted,
  output logic      [COUNT_W-1:0] timerBCount
);

  localparam int NT = `DTEI_TIMERS;
  localparam int NB = `DTEI_SYNC_BITS;

  if (COUNT_W != `DTEI_COUNT_W || PRESCALE_W != `DTEI_PRESCALE_W) begin : gWidthCheck
    $error("dtei_top: widths must match the configuration structure");
  end

  // per-timer views of the ports
  dtei_wr_s               wrReq     [NT];
  logic [NB-1:0]          pinRaw    [NT];
  logic                   wrAccept  [NT];
  logic                   intOut    [NT];
  logic [COUNT_W-1:0]     countOut  [NT];

  assign wrReq[0]  = timerAWrite;
  assign wrReq[1]  = timerBWrite;
  assign pinRaw[0] = {timerAPrivilegedWriteOnly, timerAExternalInput};
  assign pinRaw[1] = {timerBPrivilegedWriteOnly, timerBExternalInput};

  assign timerAWriteAccepted = wrAccept[0];
  assign timerBWriteAccepted = wrAccept[1];
  assign timerAInterrupt     = intOut[0];
  assign timerBInterrupt     = intOut[1];
  assign timerACount         = countOut[0];
  assign timerBCount         = countOut[1];

  for (genvar t = 0; t < NT; t++) begin : gTimer

    logic [NB-1:0]         syncMetaQ;
    logic [NB-1:0]         syncQ;
    logic [NB-1:0]         syncCheckQ;
    logic [NB-1:0]         stableQ;
    logic                  extRise;
    logic                  privOnly;
    logic                  extLevel;
    dtei_cfg_s             cfgQ;
    logic [PRESCALE_W-1:0] preCountQ;
    logic                  preTick;
    logic                  tick;
    logic                  accept;

    // two-stage synchroniser; the first stage feeds only the second
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        syncMetaQ <= '0;
        syncQ     <= '0;
      end else begin
        syncMetaQ <= pinRaw[t];
        syncQ     <= syncMetaQ;
      end
    end

    // third stage: a change counts only once second and third stage agree
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        syncCheckQ <= '0;
      end else begin
        syncCheckQ <= syncQ;
      end
    end

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        stableQ <= '0;
      end else begin
        for (int b = 0; b < NB; b++) begin
          if (syncQ[b] == syncCheckQ[b]) begin
            stableQ[b] <= syncQ[b];
          end
        end
      end
    end

    // rising edge of the filtered external input, one cycle wide
    assign extRise  = syncQ[`DTEI_BIT_EXT] & syncCheckQ[`DTEI_BIT_EXT]
                      & ~stableQ[`DTEI_BIT_EXT];
    assign extLevel = stableQ[`DTEI_BIT_EXT];
    assign privOnly = stableQ[`DTEI_BIT_PRIV];

    // the tie-off is filtered too; it reads as open for the first few cycles after reset
    assign accept = wrReq[t].valid & (wrReq[t].priv | ~privOnly);
    assign wrAccept[t] = accept;

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        cfgQ.enable   <= `DTEI_ENABLE_RST;
        cfgQ.mode     <= MODE_INTERNAL;
        cfgQ.prescale <= `DTEI_PRESCALE_RST;
        cfgQ.reload   <= `DTEI_RELOAD_RST;
      end else if (accept) begin
        cfgQ <= wrReq[t].cfg;
      end
    end

    // prescaler gives a one-cycle enable every prescale+1 clocks
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        preCountQ <= '0;
      end else if (accept || !cfgQ.enable || preTick) begin
        preCountQ <= '0;
      end else begin
        preCountQ <= preCountQ + PRESCALE_W'(1);
      end
    end

    assign preTick = cfgQ.enable && (preCountQ == cfgQ.prescale);

    // external clock ignores the prescaler: edges are already slower than clk/2
    always_comb begin
      tick = 1'b0;
      if (cfgQ.enable) begin
        case (cfgQ.mode)
          MODE_INTERNAL:  tick = preTick;
          MODE_EXT_GATE:  tick = preTick & extLevel;
          MODE_EXT_CLOCK: tick = extRise;
          default:        tick = 1'b0;
        endcase
      end
    end

    dtei_counter #(
      .COUNT_W   (COUNT_W)
    ) uCounter (
      .clk       (clk),
      .nrst      (nrst),
      .load      (accept),
      .loadValue (wrReq[t].cfg.reload),
      .tick      (tick),
      .clearInt  (accept & wrReq[t].clearInt),
      .count     (countOut[t]),
      .interrupt (intOut[t])
    );

  end

endmodule // dtei_top

// file: dv/dtei_ext_src.sv
`timescale 1ns/1ps
module dtei_ext_src (
  // clock
  input  wire logic       clk,
  // pacing from the bench
  input  wire logic       run,
  input  wire logic [3:0] half,
  // pin
  output logic            pin
);
  logic [3:0] cnt = 4'h0;
  initial pin = 1'b0;
  // each level lasts half clocks; the bench never runs the source with half below two
  always @(posedge clk) begin
    if (run && cnt + 4'h1 >= half) begin
      cnt <= 4'h0;
      pin <= ~pin;
    end else if (run) begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule // dtei_ext_src

// file: dv/dtei_chk.sv
`timescale 1ns/1ps
module dtei_chk
  import dtei_pkg::*;
#(
  parameter int COUNT_W = 32
) (
  // clock and reset
  input wire logic               clk,
  input wire logic               nrst,
  // timer a
  input wire logic               timerAExternalInput,
  input wire logic               timerAPrivilegedWriteOnly,
  input wire logic               timerAInterrupt,
  input wire dtei_wr_s           timerAWrite,
  input wire logic               timerAWriteAccepted,
  input wire logic [COUNT_W-1:0] timerACount,
  // timer b
  input wire logic               timerBInterrupt,
  input wire dtei_wr_s           timerBWrite,
  input wire logic               timerBWriteAccepted
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [3:0] privA_q;
  logic       extA_q;
  // four past samples outlast the tie-off filter delay
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) privA_q <= 4'h0;
    else privA_q <= {privA_q[2:0], timerAPrivilegedWriteOnly};
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) extA_q <= 1'b0;
    else if (timerAWriteAccepted) extA_q <= timerAWrite.cfg.enable &&
                                            timerAWrite.cfg.mode == MODE_EXT_CLOCK;
  end
  sequence s_rise_a;
    extA_q && $rose(timerAExternalInput) && !timerAWriteAccepted
      ##1 (!timerAWriteAccepted)[*2];
  endsequence
  property p_ref_a;
    timerAWrite.valid && !timerAWrite.priv && timerAPrivilegedWriteOnly && &privA_q
      |-> !timerAWriteAccepted;
  endproperty
  property p_sync_a;
    s_rise_a |-> $stable(timerACount);
  endproperty
  property p_edge_a;
    s_rise_a ##0 timerACount != 0 ##1 !timerAWriteAccepted
      |=> timerACount == $past(timerACount, 2) - 1;
  endproperty
  property p_irq_a;
    timerACount == 0 && $past(timerACount) == 1 && !$past(timerAWriteAccepted)
      |-> timerAInterrupt;
  endproperty
  property p_clr_b;
    timerBWriteAccepted && timerBWrite.clearInt |=> !timerBInterrupt;
  endproperty
  a_ref_a: assert property (p_ref_a) else $error("refused write taken");
  a_sync_a: assert property (p_sync_a) else $error("count moved too early");
  a_edge_a: assert property (p_edge_a) else $error("edge not counted");
  a_irq_a: assert property (p_irq_a) else $error("no interrupt at zero");
  a_clr_b: assert property (p_clr_b) else $error("interrupt b not cleared");
endmodule // dtei_chk

bind dtei_top dtei_chk #(.COUNT_W(COUNT_W)) u_dtei_chk (
  .clk, .nrst, .timerAExternalInput, .timerAPrivilegedWriteOnly, .timerAInterrupt,
  .timerAWrite, .timerAWriteAccepted, .timerACount, .timerBInterrupt, .timerBWrite,
  .timerBWriteAccepted
);

// file: dv/dual_timer_external_input_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module dual_timer_external_input_bench
  import dtei_pkg::*;
;
  logic        clk, nrst, privA, privB, run, pin, prv, intA, intB, accA, accB;
  logic [3:0]  half;
  logic [31:0] cntA, cntB, rl;
  dtei_wr_s    wrA, wrB;
  int          err_total, check_count, cyc, ups, hi, n, i;
  dtei_mode_e  md;
  // one source feeds both timers so one rise count serves both
  dtei_top u_dtei_top (.clk, .nrst, .timerAExternalInput(pin),
    .timerAPrivilegedWriteOnly(privA), .timerAInterrupt(intA), .timerBExternalInput(pin),
    .timerBPrivilegedWriteOnly(privB), .timerBInterrupt(intB), .timerAWrite(wrA),
    .timerAWriteAccepted(accA), .timerACount(cntA), .timerBWrite(wrB),
    .timerBWriteAccepted(accB), .timerBCount(cntB));
  dtei_ext_src u_dtei_ext_src (.clk, .run, .half, .pin);
  function automatic logic [31:0] exp_cnt(input logic [31:0] r, input int n);
    return r - 32'(n % (r + 1));
  endfunction
  task automatic wr(input bit b, input logic p, input dtei_mode_e m, input logic [31:0] r,
                    input logic acc);
    @(posedge clk);
    if (b) wrB <= '{1'b1, p, 1'b1, '{1'b1, m, 8'h00, r}};
    else wrA <= '{1'b1, p, 1'b1, '{1'b1, m, 8'h00, r}};
    #1 `CHK("accepted", acc, b ? accB : accA)
    @(posedge clk);
    wrA.valid <= 1'b0;
    wrB.valid <= 1'b0;
    @(posedge clk) #1;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    prv <= pin;
    ups += pin && !prv;
    hi += pin;
    if (++cyc == 1000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    {nrst, privA, privB, run, prv, half} = '0;
    {wrA, wrB} = '0;
    void'($urandom(32'hfb68));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rl = $urandom_range(6, 2);
    wr(1'b0, 1'b1, MODE_INTERNAL, rl, 1'b1);
    for (i = 1; i < rl + 3; i++) begin
      `CHK("cntA", exp_cnt(rl, i), cntA)
      `CHK("intA", i >= rl, intA)
      @(posedge clk) #1;
    end
    $display("internal walk done");
    @(posedge clk) privA <= 1'b1;
    repeat (5) @(posedge clk);
    wr(1'b0, 1'b0, MODE_INTERNAL, 32'h0, 1'b0);
    `CHK("intA", 1'b1, intA)
    wr(1'b0, 1'b1, dtei_mode_e'(2'h3), 32'h55, 1'b1);
    `CHK("intA", 1'b0, intA)
    rl = $urandom();
    wr(1'b1, 1'b0, dtei_mode_e'(2'h3), rl, 1'b1);
    `CHK("cntB", rl, cntB)
    `CHK("cntA", 32'h55, cntA)
    @(posedge clk) privB <= 1'b1;
    repeat (5) @(posedge clk);
    wr(1'b1, 1'b0, MODE_INTERNAL, 32'h0, 1'b0);
    `CHK("cntB", rl, cntB)
    $display("privilege done");
    for (i = 0; i < 3; i++) begin
      rl = (i == 1) ? 32'h4 : $urandom_range(50, 30);
      md = (i == 2) ? MODE_EXT_GATE : MODE_EXT_CLOCK;
      wr(1'b0, 1'b1, md, rl, 1'b1);
      wr(1'b1, 1'b1, md, rl, 1'b1);
      ups = 0;
      hi = 0;
      @(posedge clk);
      half <= 4'($urandom_range(5, 2));
      run <= 1'b1;
      repeat (60) @(posedge clk);
      // stop just after a fall so the pin rests low and no level is cut short
      while (!(prv && !pin)) @(posedge clk);
      run <= 1'b0;
      // wait for the last level to pass the synchroniser and filter before the counts are read
      repeat (30) @(posedge clk);
      n = (i == 2) ? hi : ups;
      #1 `CHK("cntA", exp_cnt(rl, n), cntA)
      `CHK("cntB", exp_cnt(rl, n), cntB)
      `CHK("intA", n >= rl, intA)
      `CHK("intB", n >= rl, intB)
    end
    $display("external clock done");
    end_sim();
  end
endmodule // dual_timer_external_input_bench
